/* rtl/lcdcmd_consts.svh */
// offsets, field positions, opcodes and timing counts of the lcd command decoder
`ifndef LCDCMD_CONSTS_SVH
`define LCDCMD_CONSTS_SVH
// wishbone register byte addresses
`define LCDCMD_ADDR_CMD      4'h0
`define LCDCMD_ADDR_DATA     4'h4
`define LCDCMD_ADDR_DISP     4'h8
`define LCDCMD_ADDR_DBG      4'hc
// command opcodes, full byte or masked pattern
`define LCDCMD_OP_DISP       8'hae
`define LCDCMD_OP_DISP_MASK  8'hfe
`define LCDCMD_OP_START      8'hc0
`define LCDCMD_OP_START_MASK 8'he0
`define LCDCMD_OP_PAGE       8'hb8
`define LCDCMD_OP_PAGE_MASK  8'hfc
`define LCDCMD_OP_SEGORD     8'ha0
`define LCDCMD_OP_STATIC     8'ha4
`define LCDCMD_OP_DUTY       8'ha8
`define LCDCMD_OP_RMW        8'he0
`define LCDCMD_OP_END        8'hee
`define LCDCMD_OP_RESET      8'he2
`define LCDCMD_OP_FULL_MASK  8'hff
// column limits
`define LCDCMD_COL_STOP      7'h50
`define LCDCMD_COL_LAST      7'h4f
`define LCDCMD_SEG_TOP       7'h4f
// status bit positions
`define LCDCMD_ST_BUSY       7
`define LCDCMD_ST_SEGORD     6
`define LCDCMD_ST_OFF        5
`define LCDCMD_ST_INIT       4
// reset values
`define LCDCMD_RST_PAGE      2'h3
`define LCDCMD_RST_LINE      5'h00
// busy time after each instruction and init time, in ns
`define LCDCMD_BUSY_NS       200
`define LCDCMD_INIT_NS       1000
`define LCDCMD_CLK_NS        40
`define LCDCMD_BUSY_CYC      ((`LCDCMD_BUSY_NS + `LCDCMD_CLK_NS - 1) / `LCDCMD_CLK_NS)
`define LCDCMD_INIT_CYC      ((`LCDCMD_INIT_NS + `LCDCMD_CLK_NS - 1) / `LCDCMD_CLK_NS)
`endif

/* rtl/lcdcmd_decoder.sv */
// instruction decoder, display ram and wishbone slave of the lcd segment driver
//
// Summary of operation
// - cycle kind comes from reg_select and direction: data, status or command
// - display on/off switches display only; bit 1 means on
// - display off together with static drive on gives power save
// - start line command loads 5-bit line shown on first_common_row
// - shown area runs from start line for duty count lines
// - page command loads 2-bit page used for host ram access
// - page changes never alter what is displayed
// - command with top bit zero loads 7-bit column, valid 0 to 4f
// - column advances per access, stops at 50h, page never changes
// - status: busy b7, segment order b6, display off b5, init b4
// - segment order bit reads 1 for normal, 0 for reversed mapping
// - display status bit is 0 when on, 1 when off
// - init bit is 1 during pin reset or reset command init
// - data write stores byte at page and column, then column advances
// - data read returns byte, advancing column only outside rmw mode
// - segment order command low bit picks normal or reversed mapping
// - static drive on forces commons active and lights whole display unless display is off
// - duty bit 0 gives 1/16, 1 gives 1/32, matching master driver
// - in rmw mode writes advance column, reads leave it
// - end command leaves rmw mode and restores saved column
// - reset command sets start line 0 and page 3, ram untouched
`include "lcdcmd_consts.svh"
`default_nettype none
module lcdcmd_decoder
	import lcdcmd_pkg::*;
(
	input  wire logic         clk_sys_i,
	input  wire logic         rst_n_i,
	input  wire logic         wb_cyc_i,
	input  wire logic         wb_stb_i,
	input  wire logic         wb_we_i,
	input  wire logic [3:0]   wb_adr_i,
	input  wire logic [3:0]   wb_sel_i,
	input  wire logic [31:0]  wb_dat_i,
	output logic      [31:0]  wb_dat_o,
	output logic              wb_ack_o,
	input  wire logic [6:0]   scan_column_i,
	input  wire logic [4:0]   scan_row_i,
	output lcdcmd_disp_t      disp_o,
	output logic      [7:0]   scan_data_o,
	output logic              common_force_o
);
	////////////////////////////////////////////////////////////////////////////
	// helpers

	// column after one access, held at the stop address
	function automatic logic [6:0] col_step(input logic [6:0] c);
		col_step = (c >= `LCDCMD_COL_STOP) ? c : c + 7'h01;
	endfunction

	// ram index from page and column
	function automatic logic [8:0] ram_index(input logic [1:0] p, input logic [6:0] c);
		ram_index = {p, c};
	endfunction

	// opcode match under a mask, shared by every instruction pattern but the column command
	function automatic logic op_hit(input logic [7:0] b, input logic [7:0] op,
		input logic [7:0] mask);
		op_hit = ((b & mask) == op);
	endfunction

	localparam logic [4:0] BUSY_CYC = 5'(`LCDCMD_BUSY_CYC);
	localparam logic [4:0] INIT_CYC = 5'(`LCDCMD_INIT_CYC);

	////////////////////////////////////////////////////////////////////////////
	// state and display ram

	lcdcmd_state_t st;
	lcdcmd_state_t next_st;
	logic [7:0]    ram [0:511];
	logic          ram_we;
	logic [8:0]    ram_wa;
	logic [7:0]    ram_wd;
	logic [7:0]    ram_rd;
	logic [7:0]    scan_q;
	logic [6:0]    scan_col;
	logic [4:0]    scan_line;
	logic          req;
	logic [7:0]    status;
	logic [7:0]    cmd;
	logic          busy;
	logic          hit_col;
	logic          hit_disp;
	logic          hit_start;
	logic          hit_page;
	logic          hit_segord;
	logic          hit_static;
	logic          hit_duty;
	logic          hit_rmw;
	logic          hit_end;
	logic          hit_reset;
	logic          acc_data;
	logic          acc_cmd;
	logic          acc_disp;
	logic          acc_dbg;

	assign req  = wb_cyc_i && wb_stb_i && (st.phase == LCDCMD_IDLE);
	assign cmd  = wb_dat_i[7:0];
	assign ram_rd = ram[ram_index(st.page, st.column)];

	// busy while the instruction timer runs or init is pending, so polling sees it
	assign busy = (st.count != 5'h00) || st.init;

	// status byte, low nibble zero
	always_comb begin
		status = 8'h00;
		status[`LCDCMD_ST_BUSY]   = busy;
		status[`LCDCMD_ST_SEGORD] = st.disp.segment_normal;
		status[`LCDCMD_ST_OFF]    = ~st.disp.display_on;
		status[`LCDCMD_ST_INIT]   = st.init;
	end

	// register select decode: command and status low, ram data high
	always_comb begin
		acc_data = 1'b0;
		acc_cmd  = 1'b0;
		acc_disp = 1'b0;
		acc_dbg  = 1'b0;
		if (wb_adr_i == `LCDCMD_ADDR_DATA) begin
			acc_data = 1'b1;
		end else if (wb_adr_i == `LCDCMD_ADDR_CMD) begin
			acc_cmd = 1'b1;
		end else if (wb_adr_i == `LCDCMD_ADDR_DISP) begin
			acc_disp = 1'b1;
		end else if (wb_adr_i == `LCDCMD_ADDR_DBG) begin
			acc_dbg = 1'b1;
		end
	end

	// instruction pattern decode; patterns do not overlap, the chain below gives priority
	always_comb begin
		hit_col    = (cmd[7] == 1'b0);
		hit_disp   = op_hit(cmd, `LCDCMD_OP_DISP, `LCDCMD_OP_DISP_MASK);
		hit_start  = op_hit(cmd, `LCDCMD_OP_START, `LCDCMD_OP_START_MASK);
		hit_page   = op_hit(cmd, `LCDCMD_OP_PAGE, `LCDCMD_OP_PAGE_MASK);
		hit_segord = op_hit(cmd, `LCDCMD_OP_SEGORD, `LCDCMD_OP_DISP_MASK);
		hit_static = op_hit(cmd, `LCDCMD_OP_STATIC, `LCDCMD_OP_DISP_MASK);
		hit_duty   = op_hit(cmd, `LCDCMD_OP_DUTY, `LCDCMD_OP_DISP_MASK);
		hit_rmw    = op_hit(cmd, `LCDCMD_OP_RMW, `LCDCMD_OP_FULL_MASK);
		hit_end    = op_hit(cmd, `LCDCMD_OP_END, `LCDCMD_OP_FULL_MASK);
		hit_reset  = op_hit(cmd, `LCDCMD_OP_RESET, `LCDCMD_OP_FULL_MASK);
	end

	////////////////////////////////////////////////////////////////////////////
	// next state

	always_comb begin
		next_st = st;
		ram_we  = 1'b0;
		ram_wa  = ram_index(st.page, st.column);
		ram_wd  = wb_dat_i[7:0];
		case (st.phase)
			LCDCMD_IDLE: begin
				if (st.count != 5'h00) begin
					next_st.count = st.count - 5'h01;
				end else begin
					next_st.init = 1'b0;
				end
				if (req) begin
					next_st.phase = LCDCMD_ACK;
					next_st.dat   = 32'h0000_0000;
					// data address is reg_select high, command address low
					if (acc_data) begin
						if (wb_we_i) begin
							if (wb_sel_i[0] && st.column <= `LCDCMD_COL_LAST) begin
								ram_we = 1'b1;
							end
							if (wb_sel_i[0]) begin
								next_st.column = col_step(st.column);
							end
						end else begin
							// pipelined read: previous latch out, fresh byte
							next_st.dat        = {24'h000000, st.read_latch};
							next_st.read_latch = ram_rd;
							if (!st.rmw) begin
								next_st.column = col_step(st.column);
							end
						end
					end else if (acc_cmd) begin
						if (!wb_we_i) begin
							next_st.dat = {24'h000000, status};
						end else if (wb_sel_i[0]) begin
							next_st.count = BUSY_CYC;
							if (hit_col) begin
								next_st.column     = cmd[6:0];
								next_st.read_latch = {1'b0, cmd[6:0]};
							end else if (hit_disp) begin
								next_st.disp.display_on = cmd[0];
							end else if (hit_start) begin
								next_st.disp.start_line = cmd[4:0];
							end else if (hit_page) begin
								next_st.page = cmd[1:0];
							end else if (hit_segord) begin
								next_st.disp.segment_normal = cmd[0];
							end else if (hit_static) begin
								next_st.disp.static_drive = cmd[0];
							end else if (hit_duty) begin
								next_st.disp.duty_32 = cmd[0];
							end else if (hit_rmw) begin
								next_st.rmw          = 1'b1;
								next_st.saved_column = st.column;
							end else if (hit_end) begin
								next_st.rmw = 1'b0;
								if (st.rmw) begin
									next_st.column = st.saved_column;
								end
							end else if (hit_reset) begin
								next_st.disp.start_line = `LCDCMD_RST_LINE;
								next_st.page            = `LCDCMD_RST_PAGE;
								next_st.init            = 1'b1;
								next_st.count           = INIT_CYC;
							end else begin
								next_st.count = st.count;
							end
						end
					end else if (acc_disp) begin
						next_st.dat = {22'h0, st.disp};
					end else if (acc_dbg) begin
						next_st.dat = {16'h0000, 1'b0, st.rmw, st.page, 5'h00, st.column};
					end
				end
			end
			LCDCMD_ACK: begin
				next_st.phase = LCDCMD_BUSY;
				if (st.count != 5'h00) begin
					next_st.count = st.count - 5'h01;
				end
			end
			LCDCMD_BUSY: begin
				// one idle cycle so the master can drop stb
				next_st.phase = LCDCMD_IDLE;
				if (st.count != 5'h00) begin
					next_st.count = st.count - 5'h01;
				end
			end
			default: begin
				next_st.phase = LCDCMD_IDLE;
			end
		endcase
		// power save whenever off and static together
		next_st.disp.power_save = ~next_st.disp.display_on & next_st.disp.static_drive;
	end

	////////////////////////////////////////////////////////////////////////////
	// registers

	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			st                     <= '0;
			st.phase               <= LCDCMD_IDLE;
			st.disp.segment_normal <= 1'b1;
			st.page                <= `LCDCMD_RST_PAGE;
			st.init                <= 1'b1;
			st.count               <= INIT_CYC;
		end else begin
			st <= next_st;
		end
	end

	// display ram write port and scan read port
	always_ff @(posedge clk_sys_i) begin
		if (ram_we) begin
			ram[ram_wa] <= ram_wd;
		end
		scan_q <= ram[ram_index(scan_line[4:3], scan_col)];
	end

	////////////////////////////////////////////////////////////////////////////
	// display scan path

	// shown line is the start line plus the row cut to duty count, wrapping at 32 lines
	always_comb begin
		scan_line = st.disp.start_line + (st.disp.duty_32 ? scan_row_i : {1'b0, scan_row_i[3:0]});
		scan_col  = st.disp.segment_normal ? scan_column_i : `LCDCMD_SEG_TOP - scan_column_i;
	end

	assign wb_ack_o       = (st.phase == LCDCMD_ACK);
	assign wb_dat_o       = st.dat;
	assign disp_o         = st.disp;
	assign scan_data_o    = scan_q;
	assign common_force_o = st.disp.static_drive & ~st.disp.power_save;
endmodule
`default_nettype wire

/* rtl/lcdcmd_pkg.sv */
// types of the lcd segment command decoder
`default_nettype none
package lcdcmd_pkg;
	typedef enum logic [1:0] {
		LCDCMD_IDLE,
		LCDCMD_ACK,
		LCDCMD_BUSY
	} lcdcmd_phase_t;

	// display settings that leave the block toward the drive logic
	typedef struct packed {
		logic       display_on;
		logic       static_drive;
		logic       power_save;
		logic       segment_normal;
		logic       duty_32;
		logic [4:0] start_line;
	} lcdcmd_disp_t;

	// whole state of the decoder
	typedef struct packed {
		lcdcmd_phase_t phase;
		lcdcmd_disp_t  disp;
		logic [1:0]    page;
		logic [6:0]    column;
		logic [6:0]    saved_column;
		logic          rmw;
		logic          init;
		logic [4:0]    count;
		logic [7:0]    read_latch;
		logic [31:0]   dat;
	} lcdcmd_state_t;
endpackage
`default_nettype wire

/* testbench/lcdcmd_decoder_sva.sv */
// port assertions of the lcd command decoder
`default_nettype none
module lcdcmd_decoder_sva
	import lcdcmd_pkg::*;
(
	input wire logic         clk_sys_i,
	input wire logic         rst_n_i,
	input wire logic         wb_cyc_i,
	input wire logic         wb_stb_i,
	input wire logic         wb_we_i,
	input wire logic [3:0]   wb_adr_i,
	input wire logic [3:0]   wb_sel_i,
	input wire logic [31:0]  wb_dat_i,
	input wire logic [31:0]  wb_dat_o,
	input wire logic         wb_ack_o,
	input wire logic [6:0]   scan_column_i,
	input wire logic [4:0]   scan_row_i,
	input wire lcdcmd_disp_t disp_o,
	input wire logic [7:0]   scan_data_o,
	input wire logic         common_force_o
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (!rst_n_i);
	logic cmd;
	logic st;
	// acked command write and acked status read
	assign cmd = wb_ack_o && wb_we_i && wb_adr_i == 4'h0 && wb_sel_i[0];
	assign st = wb_ack_o && !wb_we_i && wb_adr_i == 4'h0;
	ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
	ack_cause_a: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i))
		else $error("ack without request");
	unmapped_a: assert property (wb_ack_o && wb_adr_i[1:0] != 2'h0 |-> wb_dat_o == 32'h0)
		else $error("unmapped read not zero");
	disp_on_a: assert property (cmd && wb_dat_i[7:1] == 7'h57 |->
		disp_o.display_on == wb_dat_i[0]) else $error("display on wrong");
	power_save_a: assert property ((!disp_o.display_on && disp_o.static_drive) [*2] |->
		disp_o.power_save) else $error("power save missing");
	start_line_a: assert property (cmd && wb_dat_i[7:5] == 3'h6 |->
		disp_o.start_line == wb_dat_i[4:0]) else $error("start line wrong");
	page_keep_a: assert property (cmd && wb_dat_i[7:2] == 6'h2e |-> $stable(disp_o))
		else $error("page changed display");
	status_bits_a: assert property (st |-> wb_dat_o[3:0] == 4'h0 &&
		wb_dat_o[5] == !disp_o.display_on) else $error("status bits wrong");
	seg_order_a: assert property (st |-> wb_dat_o[6] == disp_o.segment_normal)
		else $error("segment order bit wrong");
	force_on_a: assert property ((disp_o.static_drive && !disp_o.power_save) [*2] |->
		common_force_o) else $error("commons not forced");
	duty_sel_a: assert property (cmd && wb_dat_i[7:1] == 7'h54 |->
		disp_o.duty_32 == wb_dat_i[0]) else $error("duty wrong");
	cover property (st && wb_dat_o[7]);
	cover property (cmd && wb_dat_i[7:0] == 8'he0);
	cover property (disp_o.power_save);
endmodule
bind lcdcmd_decoder lcdcmd_decoder_sva chk (.*);
`default_nettype wire

/* testbench/lcdcmd_decoder_tb.sv */
// self-checking bench of the lcd command decoder
`default_nettype none
module lcdcmd_decoder_tb;
	import lcdcmd_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;
	logic         clk_sys_i = 1'b0;
	logic         rst_n_i = 1'b0;
	logic         wb_cyc_i = 1'b0;
	logic         wb_we_i = 1'b0;
	logic [3:0]   wb_adr_i = 4'h0;
	logic [3:0]   wb_sel_i = 4'hf;
	logic [31:0]  wb_dat_i = 32'h0;
	logic [31:0]  wb_dat_o;
	logic         wb_ack_o;
	logic [6:0]   scan_column_i;
	logic [4:0]   scan_row_i;
	lcdcmd_disp_t disp_o;
	logic [7:0]   scan_data_o;
	logic         common_force_o;
	logic [31:0]  q;
	int           err_total = 0;
	int           n_compared = 0;
	always #20 clk_sys_i = ~clk_sys_i;
	lcdcmd_decoder dut (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .wb_cyc_i(wb_cyc_i),
		.wb_stb_i(wb_cyc_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
		.wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
		.scan_column_i(scan_column_i), .scan_row_i(scan_row_i), .disp_o(disp_o),
		.scan_data_o(scan_data_o), .common_force_o(common_force_o));
	lcdcmd_scan_model scan (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
		.scan_column_o(scan_column_i), .scan_row_o(scan_row_i));
	// one wishbone cycle: held to the rising edge that samples ack, then one idle cycle
	task automatic bus(input logic [3:0] a, input logic w, input logic [7:0] d);
		wb_cyc_i <= 1'b1;
		wb_we_i <= w;
		wb_adr_i <= a;
		wb_dat_i <= {24'h0, d};
		do @(posedge clk_sys_i); while (wb_ack_o !== 1'b1);
		q = wb_dat_o;
		wb_cyc_i <= 1'b0;
		@(posedge clk_sys_i);
	endtask
	task automatic chk(input string s, input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			err_total++;
			$display("CHECK FAILED %s expected %h seen %h", s, exp, seen);
		end
	endtask
	task automatic look(input logic [3:0] a, input string s, input logic [31:0] exp);
		bus(a, 1'b0, 8'h00);
		chk(s, q, exp);
	endtask
	// poll status until busy clears; cmd writes a command first
	task automatic idle_wait;
		do bus(4'h0, 1'b0, 8'h00); while (q[7] !== 1'b0);
	endtask
	task automatic cmd(input logic [7:0] d);
		bus(4'h0, 1'b1, d);
		idle_wait;
	endtask
	task automatic test_done;
		$display("compared %0d mismatches %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	initial begin
		#400000;
		err_total++;
		test_done;
	end
	initial begin
		repeat (5) @(posedge clk_sys_i);
		rst_n_i <= 1'b1;
		look(4'h0, "init status", 32'hf0);
		repeat (30) @(posedge clk_sys_i);
		look(4'h0, "idle status", 32'h60);
		look(4'h2, "unmapped", 32'h0);
		$display("test reset done");
		cmd(8'haf);
		look(4'h0, "on status", 32'h40);
		cmd(8'ha5);
		look(4'h8, "static", 32'h340);
		chk("force on", {31'h0, common_force_o}, 32'h1);
		cmd(8'hae);
		look(4'h8, "power save", 32'h1c0);
		chk("force off", {31'h0, common_force_o}, 32'h0);
		bus(4'h0, 1'b1, 8'ha4);
		look(4'h0, "busy status", 32'he0);
		idle_wait;
		cmd(8'ha9);
		cmd(8'ha0);
		cmd(8'hc5);
		cmd(8'hbb);
		look(4'h8, "modes", 32'h025);
		look(4'h0, "reverse status", 32'h20);
		$display("test modes done");
		cmd(8'h4e);
		cmd(8'hb9);
		wb_sel_i <= 4'h0;
		bus(4'h4, 1'b1, 8'h77);
		wb_sel_i <= 4'hf;
		look(4'hc, "sel off", 32'h104e);
		bus(4'h4, 1'b1, 8'h11);
		bus(4'h4, 1'b1, 8'h22);
		bus(4'h4, 1'b1, 8'h33);
		look(4'hc, "column stop", 32'h1050);
		cmd(8'h4e);
		look(4'h4, "dummy", 32'h4e);
		look(4'h4, "read 4e", 32'h11);
		look(4'h4, "read 4f", 32'h22);
		// row 4 from start line 5 is line 9 of page 1; segment 1 shows column 4e
		do @(posedge clk_sys_i); while (scan_row_i !== 5'h04 || scan_column_i !== 7'h01);
		@(posedge clk_sys_i);
		chk("scan byte", {24'h0, scan_data_o}, 32'h11);
		$display("test ram done");
		cmd(8'h4e);
		cmd(8'he0);
		bus(4'h4, 1'b0, 8'h00);
		look(4'h4, "rmw read", 32'h11);
		bus(4'h4, 1'b1, 8'h55);
		look(4'hc, "rmw column", 32'h504f);
		cmd(8'hee);
		look(4'hc, "end column", 32'h104e);
		cmd(8'hff);
		look(4'hc, "ignored", 32'h104e);
		bus(4'h0, 1'b1, 8'he2);
		look(4'h0, "reset init", 32'hb0);
		idle_wait;
		look(4'h8, "reset line", 32'h020);
		bus(4'hc, 1'b0, 8'h00);
		chk("reset page", {30'h0, q[13:12]}, 32'h3);
		$display("test rmw done");
		test_done;
	end
endmodule
`default_nettype wire

/* testbench/lcdcmd_scan_model.sv */
// drive logic model sweeping the scan position
`default_nettype none
module lcdcmd_scan_model (
	input wire logic        clk_sys_i,
	input wire logic        rst_n_i,
	output logic     [6:0]  scan_column_o,
	output logic     [4:0]  scan_row_o
);
	timeunit 1ns;
	timeprecision 1ns;
	// column sweep per row, rows walk from the first common row
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			scan_column_o <= 7'h00;
			scan_row_o <= 5'h00;
		end else if (scan_column_o == 7'h4f) begin
			scan_column_o <= 7'h00;
			scan_row_o <= scan_row_o + 5'h01;
		end else
			scan_column_o <= scan_column_o + 7'h01;
	end
endmodule
`default_nettype wire
